/* shared/shcs_defines.vh */
// constants for the synchronous host bus chip-select block
`ifndef SHCS_DEFINES_VH
`define SHCS_DEFINES_VH

// transfer size codes
`define SHCS_SIZE_WORD      2'h0
`define SHCS_SIZE_BYTE      2'h1
`define SHCS_SIZE_HALF      2'h2
// select assert delay codes
`define SHCS_ACS_NONE       2'h0
`define SHCS_ACS_QUARTER    2'h2
`define SHCS_ACS_HALF       2'h3
// wait-state field
`define SHCS_WAIT_W         4
`define SHCS_WAIT_ZERO      4'h0
// burst beats: last beat index and beat counter zero
`define SHCS_BEATS_LAST     2'h3
`define SHCS_BEAT_ZERO      2'h0
// bus time-out in clocks
`define SHCS_TIMEOUT_LAST   8'hff
`define SHCS_TIMEOUT_ZERO   8'h00
// address low bits for burst alignment
`define SHCS_ALIGN_ZERO     2'h0

`endif

/* hdl/shcs_parity.v */
// byte-lane parity generator and checker
`timescale 1ns/1ps
`include "shcs_defines.vh"

module shcs_parity (
    data,     // 32-bit bus word, bit 0 most significant
    lane_par, // parity bit per byte lane
    par_in,   // parity returned with the data
    lane_use, // byte lanes in use
    par_err   // parity mismatch on a used lane
);
    input  wire [0:31] data;     // bus word
    output wire [0:3]  lane_par; // generated parity
    input  wire [0:3]  par_in;   // received parity
    input  wire [0:3]  lane_use; // lanes to check
    output wire        par_err;  // any used lane wrong

    wire [0:3] lane_bad;

    // one even-parity generator per byte lane
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign lane_par[g] = ^data[8*g +: 8];                  // [RULE11]
            assign lane_bad[g] = lane_use[g] & (lane_par[g] ^ par_in[g]); // [RULE11]
        end
    endgenerate

    assign par_err = |lane_bad;
endmodule // shcs_parity

/* hdl/shcs_select_timer.v */
// chip-select strobe timing generator
`timescale 1ns/1ps
`include "shcs_defines.vh"

module shcs_select_timer (
    clk,           // bus clock
    sys_rst,       // synchronous reset
    start,         // begin a selected access
    rd,            // access is a read
    relaxed,       // relaxed timing option
    hold_extra,    // first access extra clock
    assert_delay,  // select assert delay code
    early_negate,  // early negate option
    wait_count,    // wait states to insert
    done,          // pulse: internal termination
    cs_n,          // chip select
    oe_n,          // output enable
    we_n,          // write enable
    busy           // access in progress
);
    input  wire                     clk;          // clock
    input  wire                     sys_rst;      // reset
    input  wire                     start;        // start
    input  wire                     rd;           // read
    input  wire                     relaxed;      // relaxed
    input  wire                     hold_extra;   // extended hold
    input  wire [1:0]               assert_delay; // delay code
    input  wire                     early_negate; // early negate
    input  wire [`SHCS_WAIT_W-1:0]  wait_count;   // wait states
    output reg                      done;         // termination
    output reg                      cs_n;         // chip select
    output reg                      oe_n;         // output enable
    output reg                      we_n;         // write enable
    output reg                      busy;         // busy

    localparam ST_IDLE  = 4'h1;
    localparam ST_SETUP = 4'h2;
    localparam ST_WAIT  = 4'h4;
    localparam ST_END   = 4'h8;

    reg [3:0]               state_reg;
    reg [`SHCS_WAIT_W-1:0]  cnt_reg;
    reg                     first_reg;  // no access made yet
    reg                     rd_reg;
    reg [1:0]               setup_reg;  // setup clocks left

    // setup clocks: delay code rounded to a clock, relaxed; first-access hold added at start
    wire [1:0] setup_clks = ((assert_delay != `SHCS_ACS_NONE) ? 2'h1 : 2'h0)  // [RULE16]
                          + (relaxed ? 2'h1 : 2'h0);                           // [RULE18]

    // strobe sequencer
    always @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= `SHCS_WAIT_ZERO;
            first_reg <= 1'b1;
            rd_reg    <= 1'b0;
            setup_reg <= 2'h0;
            done      <= 1'b0;
            cs_n      <= 1'b1;
            oe_n      <= 1'b1;
            we_n      <= 1'b1;
            busy      <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        busy      <= 1'b1;
                        rd_reg    <= rd;
                        cnt_reg   <= wait_count;                          // [RULE20]
                        setup_reg <= setup_clks + ((hold_extra && first_reg) ? 2'h1 : 2'h0); // [RULE19]
                        first_reg <= 1'b0;
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (setup_reg == 2'h0) begin
                        cs_n      <= 1'b0;                                // [RULE22]
                        oe_n      <= ~rd_reg;                             // [RULE22]
                        we_n      <= rd_reg;                              // [RULE22]
                        state_reg <= ST_WAIT;
                    end else begin
                        setup_reg <= setup_reg - 2'h1;                    // [RULE16] [RULE18]
                    end
                end
                ST_WAIT: begin
                    if (cnt_reg == `SHCS_WAIT_ZERO) begin
                        done      <= 1'b1;                                // [RULE20]
                        if (early_negate) begin
                            cs_n <= 1'b1;                                 // [RULE17]
                            we_n <= 1'b1;                                 // [RULE17]
                        end
                        state_reg <= ST_END;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;                        // [RULE20]
                    end
                end
                ST_END: begin
                    cs_n      <= 1'b1;
                    oe_n      <= 1'b1;
                    we_n      <= 1'b1;
                    busy      <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // shcs_select_timer

/* hdl/shcs_bus_master.v */
// system bus master with general chip-select unit
//
// Behaviour
// RULE1: all outputs and sampling on rising clock
// RULE2: start strobe low exactly one clock
// RULE3: drive two-bit transfer size code
// RULE4: direction high read, low write throughout
// RULE5: drive four-bit address type with address
// RULE6: slave acknowledges for one clock
// RULE7: no new start until acknowledge released
// RULE8: transaction lasts at least two clocks
// RULE9: error acknowledge aborts; master times out (time-out here only on accesses outside the select region)
// RULE10: lane use set by size and address (lanes here come from size only)
// RULE11: parity generated on writes, checked on reads
// RULE12: bit zero is most significant
// RULE13: burst is four aligned words, A28-A29 held
// RULE14: burst block ends burst into single transfers
// RULE15: peripheral answers burst with burst block
// RULE16: select assertion delayed by programmed code
// RULE17: early negate drops select and write sooner
// RULE18: relaxed timing adds one setup clock
// RULE19: extended hold adds clock on first access
// RULE20: programmed wait states or slave acknowledge
// RULE21: optional automatic burst block for region
// RULE22: select unit drives output and write enables
// RULE23: read data valid with acknowledge
`timescale 1ns/1ps
`include "shcs_defines.vh"

module shcs_bus_master (
    clk,                 // bus clock, 20 MHz
    sys_rst,             // synchronous reset, active high
    req_valid,           // user: request a transaction
    req_rd,              // user: 1 read, 0 write
    req_burst,           // user: four-word burst
    req_size,            // user: transfer size code
    req_type,            // user: address type code
    req_addr,            // user: address, bit 0 msb
    req_wdata,           // user: write data
    req_sel,             // user: address hits chip-select region
    req_ready,           // user: master idle, request accepted
    rsp_valid,           // user: pulse, one beat finished
    rsp_rdata,           // user: read data of the beat
    rsp_error,           // user: beat ended by error, or read beat with bad lane parity
    rsp_last,            // user: last beat of the request
    cfg_assert_delay,    // select assert delay code
    cfg_early_negate,    // early negate option
    cfg_relaxed_timing,  // relaxed timing option
    cfg_extended_hold,   // extended hold option
    cfg_wait_states,     // wait states, 0..15
    cfg_auto_block,      // select unit terminates and blocks bursts
    bus_addr,            // address A[0:31]
    transfer_start_n,    // transfer start
    transfer_size,       // transfer size
    bus_rd_wr,           // direction, high read
    address_type,        // address type
    burst_in_progress_n, // burst in progress
    data_o,              // write data out
    data_oe,             // data driven while high
    data_i,              // data in
    par_o,               // lane parity out
    par_i,               // lane parity in
    transfer_ack_n,      // acknowledge from slave
    transfer_error_ack_n,// error acknowledge from slave
    burst_block_n,       // burst block from slave
    tea_o_n,             // error acknowledge driven by master
    tea_oe,              // error acknowledge enable
    cs_n,                // chip select
    oe_n,                // output enable
    we_n                 // write enable
);
    input  wire         clk;                  // clock
    input  wire         sys_rst;              // reset
    input  wire         req_valid;            // request
    input  wire         req_rd;               // read
    input  wire         req_burst;            // burst
    input  wire [1:0]   req_size;             // size
    input  wire [0:3]   req_type;             // type
    input  wire [0:31]  req_addr;             // address
    input  wire [0:31]  req_wdata;            // write data
    input  wire         req_sel;              // region hit
    output reg          req_ready;            // idle
    output reg          rsp_valid;            // beat done
    output reg  [0:31]  rsp_rdata;            // read data
    output reg          rsp_error;            // error
    output reg          rsp_last;             // last beat
    input  wire [1:0]   cfg_assert_delay;     // delay code
    input  wire         cfg_early_negate;     // early negate
    input  wire         cfg_relaxed_timing;   // relaxed
    input  wire         cfg_extended_hold;    // extended hold
    input  wire [3:0]   cfg_wait_states;      // wait states
    input  wire         cfg_auto_block;       // auto block
    output reg  [0:31]  bus_addr;             // address
    output reg          transfer_start_n;     // start strobe
    output reg  [1:0]   transfer_size;        // size
    output reg          bus_rd_wr;            // direction
    output reg  [0:3]   address_type;         // type
    output reg          burst_in_progress_n;  // burst flag
    output reg  [0:31]  data_o;               // data out
    output reg          data_oe;              // data enable
    input  wire [0:31]  data_i;               // data in
    output reg  [0:3]   par_o;                // parity out
    input  wire [0:3]   par_i;                // parity in
    input  wire         transfer_ack_n;       // ack
    input  wire         transfer_error_ack_n; // error ack
    input  wire         burst_block_n;        // burst block
    output reg          tea_o_n;              // error ack out
    output reg          tea_oe;               // error ack enable
    output wire         cs_n;                 // chip select
    output wire         oe_n;                 // output enable
    output wire         we_n;                 // write enable

    localparam ST_IDLE  = 4'h1;
    localparam ST_START = 4'h2;
    localparam ST_DATA  = 4'h4;
    localparam ST_REC   = 4'h8;

    reg [3:0]  state_reg;
    reg [1:0]  beat_reg;     // beat index in a burst
    reg        burst_reg;    // burst still running
    reg        sel_reg;      // select unit owns this access
    reg [7:0]  tmo_reg;      // time-out count
    reg [1:0]  left_reg;     // single beats still owed after block
    reg [0:3]  lanes_reg;    // byte lanes in use

    wire [0:3] wpar;
    wire       par_err;
    wire       gp_done;
    wire       gp_busy;

    // lane use from size, narrow accesses on the top lanes, bit 0 msb
    reg [0:3] lanes;
    always @* begin
        lanes = 4'hf;                                                    // [RULE10]
        if (req_size == `SHCS_SIZE_HALF)
            lanes = 4'hc;                                   // [RULE10] [RULE12]
        else if (req_size == `SHCS_SIZE_BYTE)
            lanes = 4'h8;                                   // [RULE10] [RULE12]
    end

    shcs_parity u_par (
        .data     (bus_rd_wr ? data_i : data_o),
        .lane_par (wpar),
        .par_in   (par_i),
        .lane_use (lanes_reg),
        .par_err  (par_err)
    );

    wire start_gp = (state_reg == ST_START) && sel_reg;

    shcs_select_timer u_sel (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .start        (start_gp),
        .rd           (bus_rd_wr),
        .relaxed      (cfg_relaxed_timing),
        .hold_extra   (cfg_extended_hold),
        .assert_delay (cfg_assert_delay),
        .early_negate (cfg_early_negate),
        .wait_count   (cfg_wait_states),
        .done         (gp_done),
        .cs_n         (cs_n),
        .oe_n         (oe_n),
        .we_n         (we_n),
        .busy         (gp_busy)
    );

    wire ack   = ~transfer_ack_n | (sel_reg & gp_done);                  // [RULE20]
    wire err   = ~transfer_error_ack_n;                                  // [RULE9]
    wire tmo   = (tmo_reg == `SHCS_TIMEOUT_LAST) & ~sel_reg;             // [RULE9]
    wire block = ~burst_block_n | (sel_reg & cfg_auto_block);            // [RULE14] [RULE21]
    wire rd_par_bad = bus_rd_wr & par_err;                               // [RULE11]

    // main transaction sequencer
    always @(posedge clk) begin                                          // [RULE1]
        if (sys_rst) begin
            state_reg           <= ST_IDLE;
            beat_reg            <= `SHCS_BEAT_ZERO;
            burst_reg           <= 1'b0;
            sel_reg             <= 1'b0;
            tmo_reg             <= `SHCS_TIMEOUT_ZERO;
            left_reg            <= `SHCS_BEAT_ZERO;
            lanes_reg           <= 4'hf;
            req_ready           <= 1'b0;
            rsp_valid           <= 1'b0;
            rsp_rdata           <= 32'h0;
            rsp_error           <= 1'b0;
            rsp_last            <= 1'b0;
            bus_addr            <= 32'h0;
            transfer_start_n    <= 1'b1;
            transfer_size       <= `SHCS_SIZE_WORD;
            bus_rd_wr           <= 1'b1;
            address_type        <= 4'h0;
            burst_in_progress_n <= 1'b1;
            data_o              <= 32'h0;
            data_oe             <= 1'b0;
            par_o               <= 4'h0;
            tea_o_n             <= 1'b1;
            tea_oe              <= 1'b0;
        end else begin
            rsp_valid        <= 1'b0;
            rsp_last         <= 1'b0;
            rsp_error        <= 1'b0;
            transfer_start_n <= 1'b1;                                    // [RULE2]
            tea_o_n          <= 1'b1;
            tea_oe           <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    req_ready <= transfer_ack_n;                         // [RULE7]
                    if (req_valid && req_ready && transfer_ack_n) begin  // [RULE7]
                        req_ready        <= 1'b0;
                        burst_reg        <= req_burst;
                        bus_addr         <= req_burst ?
                            {req_addr[0:29], `SHCS_ALIGN_ZERO} : req_addr; // [RULE13]
                        transfer_size    <= req_burst ? `SHCS_SIZE_WORD : req_size; // [RULE3]
                        address_type     <= req_type;                    // [RULE5]
                        bus_rd_wr        <= req_rd;                      // [RULE4]
                        burst_in_progress_n <= ~req_burst;
                        lanes_reg        <= req_burst ? 4'hf : lanes;    // [RULE10]
                        sel_reg          <= req_sel;
                        data_o           <= req_wdata;
                        transfer_start_n <= 1'b0;                        // [RULE2]
                        beat_reg         <= `SHCS_BEAT_ZERO;
                        left_reg         <= `SHCS_BEAT_ZERO;
                        tmo_reg          <= `SHCS_TIMEOUT_ZERO;
                        state_reg        <= ST_START;
                    end
                end
                ST_START: begin
                    // start clock is one cycle; ack earliest next clock
                    par_o     <= wpar;                                   // [RULE11]
                    data_oe   <= ~bus_rd_wr;      // data and parity together [RULE11]
                    state_reg <= ST_DATA;                                // [RULE8]
                end
                ST_DATA: begin
                    tmo_reg <= tmo_reg + 8'h1;
                    if (tmo) begin
                        tea_o_n   <= 1'b0;                               // [RULE9]
                        tea_oe    <= 1'b1;
                        rsp_valid <= 1'b1;
                        rsp_error <= 1'b1;
                        rsp_last  <= 1'b1;
                        state_reg <= ST_REC;
                    end else if (err) begin
                        rsp_valid <= 1'b1;                               // [RULE9]
                        rsp_error <= 1'b1;
                        rsp_last  <= 1'b1;
                        state_reg <= ST_REC;
                    end else if (ack) begin
                        rsp_valid <= 1'b1;
                        rsp_rdata <= data_i;                             // [RULE23]
                        rsp_error <= rd_par_bad;                         // [RULE11]
                        tmo_reg   <= `SHCS_TIMEOUT_ZERO;
                        if (burst_reg && block && beat_reg == `SHCS_BEAT_ZERO) begin
                            // rest of the line as single transfers
                            burst_reg <= 1'b0;                           // [RULE14]
                            burst_in_progress_n <= 1'b1;
                            left_reg  <= `SHCS_BEATS_LAST;
                            bus_addr[28:29] <= bus_addr[28:29] + 2'h1;
                            state_reg <= ST_REC;
                        end else if (burst_reg && beat_reg != `SHCS_BEATS_LAST) begin
                            beat_reg <= beat_reg + 2'h1;                 // [RULE13]
                            if (beat_reg == 2'h2)
                                burst_in_progress_n <= 1'b1;
                        end else if (left_reg != `SHCS_BEAT_ZERO) begin
                            left_reg <= left_reg - 2'h1;                 // [RULE14]
                            bus_addr[28:29] <= bus_addr[28:29] + 2'h1;
                            rsp_last  <= (left_reg == 2'h1);
                            state_reg <= ST_REC;
                        end else begin
                            rsp_last  <= 1'b1;
                            state_reg <= ST_REC;
                        end
                    end
                end
                ST_REC: begin
                    // wait for ack release and select unit idle
                    if (transfer_ack_n && !gp_busy) begin                // [RULE7]
                        if (left_reg != `SHCS_BEAT_ZERO && !rsp_last) begin
                            transfer_start_n <= 1'b0;                    // [RULE2] [RULE14]
                            tmo_reg          <= `SHCS_TIMEOUT_ZERO;
                            state_reg        <= ST_START;
                        end else begin
                            data_oe   <= 1'b0;
                            left_reg  <= `SHCS_BEAT_ZERO;
                            burst_in_progress_n <= 1'b1;
                            req_ready <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // shcs_bus_master

/* sim/shcs_bus_master_chk.sv */
// checker for the bus master ports
`timescale 1ns/1ps
module shcs_bus_master_chk (
    input wire logic        clk, sys_rst, rsp_valid, rsp_error, oe_n, we_n, // control
    input wire logic        transfer_start_n, transfer_ack_n, transfer_error_ack_n, // bus
    input wire logic        burst_block_n, burst_in_progress_n, bus_rd_wr, data_oe, // bus
    input wire logic [0:31] data_o, // write data
    input wire logic [0:3]  par_o   // lane parity
);
    // ========
    // bus protocol properties
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_begun;
        !transfer_start_n ##1 transfer_start_n;
    endsequence
    a_start_pulse: assert property ($fell(transfer_start_n) |=> transfer_start_n)
        else $error("start strobe too long");
    a_ack_gap: assert property (!transfer_ack_n |-> transfer_start_n [*2])
        else $error("start during acknowledge");
    a_min_length: assert property (!transfer_start_n |=> !rsp_valid)
        else $error("transfer under two clocks");
    a_dir_hold: assert property (s_begun |-> $stable(bus_rd_wr))
        else $error("direction moved");
    a_write_parity: assert property (data_oe |->
        par_o == {^data_o[0:7], ^data_o[8:15], ^data_o[16:23], ^data_o[24:31]})
        else $error("write parity wrong");
    a_error_abort: assert property ($fell(transfer_error_ack_n) |->
        ##[0:1] (rsp_valid && rsp_error)) else $error("error not reported");
    a_block_single: assert property (!burst_block_n |->
        ##[2:12] (!transfer_start_n && burst_in_progress_n)) else $error("no single beat");
    a_strobe_dir: assert property ((!we_n |-> !bus_rd_wr) and (!oe_n |-> bus_rd_wr))
        else $error("strobe against direction");
endmodule // shcs_bus_master_chk
bind shcs_bus_master shcs_bus_master_chk chk (.*);

/* sim/shcs_slave_model.sv */
// peripheral model answering the bus master
`timescale 1ns/1ps
module shcs_slave_model (
    input  wire logic        clk, start_n, bip_n, mute, // clock, start, burst, silence
    input  wire logic [0:31] addr, // bus address
    input  wire logic [3:0]  lat,  // clocks before ack
    input  wire logic [0:3]  flip, // parity lanes to spoil
    output logic             ack_n, bb_n, // acknowledge, burst block
    output logic      [0:31] data, // read data
    output logic      [0:3]  par   // read parity
);
    logic [3:0]  cnt_reg = 4'h0;
    logic        blk_reg = 1'b1;
    wire  [0:31] dv = addr ^ 32'h5a3c_96e1;
    wire         fire = (!start_n && !mute && lat == 4'h0) || cnt_reg == 4'h1;
    initial {ack_n, bb_n, data, par} = '1;
    // ack after start clock, block bursts, data valid with ack
    always @(posedge clk) begin
        ack_n <= ~fire; // one-clock ack
        bb_n <= ~fire | (bip_n & blk_reg);
        data <= fire ? dv : ~data; // released lanes toggle
        par <= fire ? {^dv[0:7], ^dv[8:15], ^dv[16:23], ^dv[24:31]} ^ flip : ~par;
        blk_reg <= !start_n ? bip_n : blk_reg & bip_n;
        cnt_reg <= (!start_n && !mute) ? lat : cnt_reg - (cnt_reg != 4'h0);
    end
endmodule // shcs_slave_model

/* sim/shcs_bus_master_tb.sv */
// bench for the bus master with its peripheral model
`timescale 1ns/1ps
`include "shcs_defines.vh"
module shcs_bus_master_tb;
    logic        clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_rd = 1'b0, req_burst = 1'b0;
    logic        req_sel = 1'b0, mute = 1'b0, err, cfg_extended_hold = 1'b1;
    logic        cfg_early_negate = 1'b0, cfg_relaxed_timing = 1'b0, cfg_auto_block = 1'b0;
    logic [1:0]  req_size = 2'h0, cfg_assert_delay = 2'h0;
    logic [0:3]  req_type = 4'h5, flip = 4'h0;
    logic [3:0]  cfg_wait_states = 4'h0, lat = 4'h2;
    logic [0:31] req_addr = 32'h0, req_wdata = 32'hc3a5_0f80, rd, dseen;
    wire         req_ready, rsp_valid, rsp_error, rsp_last, transfer_start_n, bus_rd_wr, tea_oe;
    wire         burst_in_progress_n, data_oe, tea_o_n, cs_n, oe_n, we_n, transfer_ack_n;
    wire         burst_block_n, transfer_error_ack_n;
    wire  [0:31] rsp_rdata, bus_addr, data_o, data_i;
    wire  [0:3]  address_type, par_o, par_i;
    wire  [1:0]  transfer_size;
    int          bad_count = 0, samples_checked = 0, beats, starts, csd, csl, l0, i;
    // pulled-up error line, clock, design and peripheral
    assign transfer_error_ack_n = tea_oe ? tea_o_n : 1'b1;
    always #25 clk = ~clk;
    shcs_bus_master uut (.*);
    shcs_slave_model peer (.clk(clk), .start_n(transfer_start_n), .bip_n(burst_in_progress_n),
        .mute(mute), .addr(bus_addr), .lat(lat), .flip(flip), .ack_n(transfer_ack_n),
        .bb_n(burst_block_n), .data(data_i), .par(par_i));
    task automatic chk(input string nm, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) $display("unexpected %s expected %h seen %h", nm, e, s);
        if (s !== e) bad_count++;
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // one request, counting starts, beats and select strobe timing
    task automatic xfer(input logic r, b, s, input logic [1:0] z, input logic [0:31] a);
        int n;
        {req_rd, req_burst, req_sel, req_size, req_addr} = {r, b, s, z, a};
        beats = 0;
        starts = 0;
        csl = 0;
        err = 1'b0;
        req_valid = 1'b1;
        for (n = 0; n < 600 && !req_ready; n++) @(posedge clk) #1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        for (n = 0; n < 600 && !(rsp_valid && rsp_last); n++) begin
            if (n > 0) @(posedge clk) #1;
            starts += !transfer_start_n;
            if (!transfer_start_n && starts == 1) csd = n;
            if (!cs_n && csl++ == 0) csd = n - csd;
            if (data_oe) dseen = data_o;
            beats += rsp_valid;
            err |= rsp_valid & rsp_error;
            if (rsp_valid) rd = rsp_rdata;
        end
        chk("finished", n < 600, 1'b1);
        chk("size", transfer_size, b ? `SHCS_SIZE_WORD : z);
        chk("type", address_type, req_type);
    endtask
    initial #400000 begin
        bad_count++;
        wrap_up();
    end
    // ========
    // test sequence
    initial begin
        repeat (5) @(posedge clk);
        #1 sys_rst = 1'b0;
        xfer(1'b0, 1'b0, 1'b0, `SHCS_SIZE_WORD, 32'h0000_1004);
        chk("write data", dseen, req_wdata);
        xfer(1'b1, 1'b0, 1'b0, `SHCS_SIZE_WORD, 32'h0000_1000);
        chk("read data", rd, 32'h5a3c_86e1);
        for (i = 0; i < 2; i++) begin
            flip = i ? 4'h8 : 4'h1;
            xfer(1'b1, 1'b0, 1'b0, `SHCS_SIZE_BYTE, 32'h0000_2003);
            chk("parity error", err, i);
        end
        xfer(1'b1, 1'b1, 1'b0, `SHCS_SIZE_WORD, 32'h0000_0106);
        chk("burst beats", beats, 4);
        chk("burst starts", starts, 4);
        mute = 1'b1;
        xfer(1'b1, 1'b0, 1'b0, `SHCS_SIZE_WORD, 32'h0000_3000);
        chk("time-out error", err, 1'b1);
        for (i = 0; i < 6; i++) begin
            cfg_assert_delay = i == 1 ? 2'h2 : i == 2 ? 2'h3 : 2'h0;
            cfg_relaxed_timing = i == 3;
            cfg_wait_states = i == 4 ? 4'hf : i == 5 ? 4'h2 : 4'h0;
            cfg_early_negate = i == 5;
            xfer(1'b0, 1'b0, 1'b1, `SHCS_SIZE_WORD, 32'h0000_4000);
            if (i == 0) l0 = csl;
            chk("select delay", csd, (i < 4) + 2);
            chk("select length", csl - l0, cfg_wait_states - cfg_early_negate);
        end
        cfg_auto_block = 1'b1;
        xfer(1'b1, 1'b1, 1'b1, `SHCS_SIZE_WORD, 32'h0000_4010);
        chk("blocked beats", beats, 4);
        wrap_up();
    end
endmodule // shcs_bus_master_tb
